// *** core/crd_slave.sv ***
// Notes on behaviour
// - Answer only the four-word address block that the straps select.
// - Bits 12:3 match straps: fitted wants zero.
// - Bits 17:13 must all be one.
// - Lowest address bit selects byte only.
// - Bits 2:1 decode to select 0,2,4,6.
// - Select 6 has no register but answers.
// - Modes 00,01 gate in; 10,11 gate out.
// - Byte bit steers low or high out gate.
// - All read; only status accepts writes.
// - Reads return status, column, code or zero.
// - Column buffer is twelve parallel zone bits.
// - Encoder yields eight-bit code in low byte.
// - Sixteen-bit status reports and accepts commands.
// - Transfers need select and matching gate.
// - Decode uses address, mode and strap inputs.
// - Out means master to device, in reverse.
// - Inhibit input low withholds the acknowledge.
`timescale 1ns/10ps
`default_nettype none

module crd_slave (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [17:0] bus_addr,
	input wire logic [1:0] bus_mode,
	input wire logic bus_msyn,
	input wire logic acknowledge_inhibit_n,
	input wire logic [9:0] address_strap,
	input wire logic [15:0] bus_data_in,
	input wire logic [11:0] column_image_buffer,
	input wire logic [15:0] reader_status,
	output logic [15:0] bus_data_out,
	output logic bus_data_oe,
	output logic bus_ssyn,
	output logic [15:0] card_status_control,
	output logic command_strobe
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [2:0] msyn_sync;
		logic msyn;
		crd_pkg::crd_state_t state;
		logic [15:0] ctrl;
		logic [15:0] rdata;
		logic rd_oe;
		logic cmd;
	} crd_regs_t;

	crd_regs_t r_q;
	crd_regs_t r_d;
	crd_pkg::crd_req_t req;
	crd_pkg::crd_dec_t dec;
	logic [7:0] code;

	// Address match against region and straps, select and gate decode.
	function automatic crd_pkg::crd_dec_t decode(input crd_pkg::crd_req_t rq, input logic [9:0] strap);
		crd_pkg::crd_dec_t d;
		d.match = (rq.addr[17:crd_pkg::TOP_LSB] == crd_pkg::TOP_REGION)
			&& (rq.addr[12:crd_pkg::STRAP_LSB] == ~strap);
		d.sel = 4'h1 << rq.addr[2:1];
		d.gate_in = (rq.mode == crd_pkg::MODE_DATI) || (rq.mode == crd_pkg::MODE_DATIP);
		// The byte bit alone steers a write to the low or the high gate.
		d.gate_out_low = rq.mode[1] && !rq.addr[0];
		d.gate_out_high = rq.mode[1] && rq.addr[0];
		return d;
	endfunction

	// ****************************************************************
	// Decode
	// ****************************************************************
	// Address and mode are stable while the strobe is up, so they need no synchroniser.
	assign req.addr = bus_addr;
	assign req.mode = bus_mode;
	assign req.msyn = r_q.msyn;
	assign dec = decode(req, address_strap);

	// The compressor works on the live column, so a read returns the code present at the taking edge.
	crd_encoder u_enc (
		.column(column_image_buffer),
		.code(code)
	);

	// Next state: the strobe passes three flops and counts when the last two agree.
	always_comb begin
		r_d = r_q;
		r_d.msyn_sync = {r_q.msyn_sync[1:0], bus_msyn};
		// A one-edge glitch on the strobe is dropped because the last two stages must agree.
		if (r_q.msyn_sync[2] == r_q.msyn_sync[1]) begin
			r_d.msyn = r_q.msyn_sync[2];
		end
		r_d.cmd = 1'b0;
		// A cycle is taken only from idle, so a strobe that stays high is never answered twice.
		case (r_q.state)
			crd_pkg::ST_IDLE: begin
				r_d.rd_oe = 1'b0;
				if (req.msyn && dec.match) begin
					r_d.state = crd_pkg::ST_ACK;
					if (dec.gate_in) begin
						r_d.rd_oe = 1'b1;
						r_d.rdata = 16'h0000;
						if (dec.sel[crd_pkg::SEL_STATUS]) begin
							r_d.rdata = r_q.ctrl | (reader_status & ~crd_pkg::STATUS_WR_MASK);
						end else if (dec.sel[crd_pkg::SEL_COLUMN]) begin
							r_d.rdata = {4'h0, column_image_buffer};
						end else if (dec.sel[crd_pkg::SEL_CODE]) begin
							r_d.rdata = {8'h00, code};
						end
					end else if (dec.gate_out_low && dec.sel[crd_pkg::SEL_STATUS]) begin
						// High-byte gate is left open, so only the low byte is loaded.
						r_d.ctrl = (bus_data_in & crd_pkg::STATUS_WR_MASK)
							| (r_q.ctrl & ~crd_pkg::STATUS_WR_MASK);
						r_d.cmd = 1'b1;
					end
				end
			end
			crd_pkg::ST_ACK: begin
				// The master owns the end of the cycle, so the answer stands until its strobe drops.
				if (!req.msyn) begin
					r_d.state = crd_pkg::ST_IDLE;
					r_d.rd_oe = 1'b0;
				end
			end
			default: begin
				// An unreachable code falls back to idle and stops driving the data lines.
				r_d.state = crd_pkg::ST_IDLE;
				r_d.rd_oe = 1'b0;
			end
		endcase
	end

	// Register the whole state in one place.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			r_q.msyn_sync <= 3'h0;
			r_q.msyn <= 1'b0;
			r_q.state <= crd_pkg::ST_IDLE;
			r_q.ctrl <= crd_pkg::STATUS_RESET;
			// Read data is cleared too, so nothing stale waits behind the output enable.
			r_q.rdata <= 16'h0000;
			r_q.rd_oe <= 1'b0;
			r_q.cmd <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// Acknowledge is withheld while the inhibit pin is grounded.
	assign bus_ssyn = (r_q.state == crd_pkg::ST_ACK) && acknowledge_inhibit_n;
	assign bus_data_out = r_q.rdata;
	assign bus_data_oe = r_q.rd_oe;
	assign card_status_control = r_q.ctrl;
	assign command_strobe = r_q.cmd;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence strobe_hit;
		req.msyn && dec.match && r_q.state == crd_pkg::ST_IDLE;
	endsequence

	ack_on_hit_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##1 acknowledge_inhibit_n |-> bus_ssyn)
		else $error("acknowledge missing after matching strobe");
	no_ack_miss_a: assert property (@(posedge clk) disable iff (!nrst)
		r_q.state == crd_pkg::ST_IDLE && !(req.msyn && dec.match) |=> !bus_ssyn)
		else $error("acknowledge on unmatched address");
	region_check_a: assert property (@(posedge clk) disable iff (!nrst)
		bus_ssyn |-> &bus_addr[17:crd_pkg::TOP_LSB])
		else $error("acknowledge outside top region");
	inhibit_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		!acknowledge_inhibit_n |-> !bus_ssyn)
		else $error("acknowledge while inhibited");
	ack_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		bus_ssyn && req.msyn && acknowledge_inhibit_n |=> bus_ssyn)
		else $error("acknowledge dropped early");
	ack_release_a: assert property (@(posedge clk) disable iff (!nrst)
		bus_ssyn && !req.msyn |=> !bus_ssyn)
		else $error("acknowledge kept after strobe");
	code_read_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 dec.gate_in && dec.sel[crd_pkg::SEL_CODE] |=> bus_data_out == {8'h00, $past(code)})
		else $error("wrong compressed code");
	column_read_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 dec.gate_in && dec.sel[crd_pkg::SEL_COLUMN]
		|=> bus_data_out == {4'h0, $past(column_image_buffer)} && bus_data_oe)
		else $error("wrong column data");
	buffer_ro_a: assert property (@(posedge clk) disable iff (!nrst)
		!(req.msyn && dec.match && r_q.state == crd_pkg::ST_IDLE
		&& dec.gate_out_low && dec.sel[crd_pkg::SEL_STATUS])
		|=> $stable(card_status_control))
		else $error("status changed without a write");
	spare_read_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 dec.sel[crd_pkg::SEL_SPARE] && dec.gate_in |=> bus_data_out == 16'h0000)
		else $error("spare word not zero");

	// ****************************************************************
	// Checks on the compressor
	// ****************************************************************
	// The code is rebuilt from the zone positions, so a slip in the compressor's wiring cannot hide.
	zone_map_a: assert property (@(posedge clk) disable iff (!nrst)
		code[7:3] == {column_image_buffer[11:9], column_image_buffer[0], column_image_buffer[1]})
		else $error("zone bits of the compressed code misplaced");
	// Each octal bit is the OR of the zones whose number carries that bit.
	octal_low_a: assert property (@(posedge clk) disable iff (!nrst)
		code[0] == (column_image_buffer[8] | column_image_buffer[6]
		| column_image_buffer[4] | column_image_buffer[2]))
		else $error("octal bit 0 wrong");
	octal_mid_a: assert property (@(posedge clk) disable iff (!nrst)
		code[1] == (column_image_buffer[7] | column_image_buffer[6]
		| column_image_buffer[3] | column_image_buffer[2]))
		else $error("octal bit 1 wrong");
	octal_high_a: assert property (@(posedge clk) disable iff (!nrst)
		code[2] == (column_image_buffer[5] | column_image_buffer[4]
		| column_image_buffer[3] | column_image_buffer[2]))
		else $error("octal bit 2 wrong");

	// ****************************************************************
	// Checks on the handshake timing
	// ****************************************************************
	// A fresh strobe on an idle slave with a matching address and no inhibit.
	sequence strobe_rise;
		$rose(bus_msyn) && dec.match && acknowledge_inhibit_n
		&& r_q.state == crd_pkg::ST_IDLE && !r_q.msyn;
	endsequence

	// The strobe filter costs a few edges before the acknowledge can follow.
	sequence ack_settles;
		##[3:6] bus_ssyn;
	endsequence

	// The master lets go of an acknowledged cycle.
	sequence strobe_fall;
		$fell(bus_msyn) && bus_ssyn;
	endsequence

	sequence ack_clears;
		##[3:6] !bus_ssyn;
	endsequence

	// The answer comes neither before the filter has passed the strobe nor long after.
	ack_latency_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_rise |-> ack_settles)
		else $error("acknowledge late after strobe");
	ack_early_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_rise |-> !bus_ssyn [*3])
		else $error("acknowledge before the strobe was filtered");
	// Dropping the strobe releases the acknowledge once the filter has seen it.
	ack_drop_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_fall |-> ack_clears)
		else $error("acknowledge stuck after strobe fell");
	strap_match_a: assert property (@(posedge clk) disable iff (!nrst)
		bus_ssyn |-> bus_addr[12:crd_pkg::STRAP_LSB] == ~address_strap)
		else $error("acknowledge against the straps");
	miss_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		r_q.state == crd_pkg::ST_IDLE && !dec.match |=> !bus_data_oe)
		else $error("data driven for a foreign address");

	// ****************************************************************
	// Checks on reads and writes
	// ****************************************************************
	// The status word is the stored command bits with the reader bits around them.
	status_read_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 dec.gate_in && dec.sel[crd_pkg::SEL_STATUS]
		|=> bus_data_out == ($past(card_status_control)
		| ($past(reader_status) & ~crd_pkg::STATUS_WR_MASK)))
		else $error("wrong status word");
	// Only input cycles drive the data lines, and only while the slave is in the acknowledge state.
	read_oe_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 dec.gate_in |=> bus_data_oe)
		else $error("read without data enable");
	write_no_oe_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 bus_mode[1] |=> !bus_data_oe)
		else $error("data driven on an output cycle");
	oe_in_ack_a: assert property (@(posedge clk) disable iff (!nrst)
		bus_data_oe |-> r_q.state == crd_pkg::ST_ACK)
		else $error("data enable outside a cycle");
	// A low-byte write to the status word loads the command bits and pulses the strobe.
	status_write_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 dec.gate_out_low && dec.sel[crd_pkg::SEL_STATUS]
		|=> ((card_status_control ^ $past(bus_data_in)) & crd_pkg::STATUS_WR_MASK) == 16'h0000
		&& command_strobe)
		else $error("status write lost");
	high_byte_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 dec.gate_out_high |=> $stable(card_status_control) && !command_strobe)
		else $error("high byte write took effect");
	write_keep_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 bus_mode[1] && !dec.sel[crd_pkg::SEL_STATUS]
		|=> $stable(card_status_control) && !command_strobe)
		else $error("buffer write took effect");
	spare_ack_a: assert property (@(posedge clk) disable iff (!nrst)
		strobe_hit ##0 dec.sel[crd_pkg::SEL_SPARE] |=> r_q.state == crd_pkg::ST_ACK)
		else $error("spare word not answered");
	// Bits outside the command mask never stick in the stored word.
	status_bits_a: assert property (@(posedge clk) disable iff (!nrst)
		(card_status_control & ~crd_pkg::STATUS_WR_MASK) == 16'h0000)
		else $error("stored status holds read-only bits");
	cmd_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
		command_strobe |=> !command_strobe)
		else $error("command strobe longer than one cycle");
	cmd_cause_a: assert property (@(posedge clk) disable iff (!nrst)
		command_strobe |-> $past(req.msyn && dec.match && r_q.state == crd_pkg::ST_IDLE
		&& dec.gate_out_low && dec.sel[crd_pkg::SEL_STATUS]))
		else $error("command strobe without a status write");
	// Reset leaves the bus quiet and the command bits cleared.
	reset_clear_a: assert property (@(posedge clk)
		!nrst |=> !bus_ssyn && !bus_data_oe && !command_strobe && card_status_control == crd_pkg::STATUS_RESET)
		else $error("outputs not cleared by reset");

endmodule // crd_slave

`default_nettype wire

// *** core/crd_pkg.sv ***
package crd_pkg;

	// ****************************************************************
	// Address layout
	// ****************************************************************
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int COL_W = 12;
	localparam int CODE_W = 8;
	localparam logic [4:0] TOP_REGION = 5'h1F;
	localparam int TOP_LSB = 13;
	localparam int STRAP_LSB = 3;
	localparam int STRAP_W = 10;
	// Strap pattern for the standard block: fitted straps on address bits 3, 7 and 8 (strap bits 0, 4 and 5).
	localparam logic [9:0] STRAP_DEFAULT = 10'h031;
	localparam logic [17:0] BLOCK_BASE = 18'h3FE70;

	// ****************************************************************
	// Register word offsets and select encodings
	// ****************************************************************
	localparam logic [1:0] SEL_STATUS = 2'h0;
	localparam logic [1:0] SEL_COLUMN = 2'h1;
	localparam logic [1:0] SEL_CODE = 2'h2;
	localparam logic [1:0] SEL_SPARE = 2'h3;
	localparam logic [2:0] OFF_STATUS = 3'h0;
	localparam logic [2:0] OFF_COLUMN = 3'h2;
	localparam logic [2:0] OFF_CODE = 3'h4;

	// ****************************************************************
	// Mode control codes
	// ****************************************************************
	localparam logic [1:0] MODE_DATI = 2'h0;
	localparam logic [1:0] MODE_DATIP = 2'h1;
	localparam logic [1:0] MODE_DATO = 2'h2;
	localparam logic [1:0] MODE_DATOB = 2'h3;

	// ****************************************************************
	// Status register layout and reset value
	// ****************************************************************
	localparam logic [15:0] STATUS_WR_MASK = 16'h0043;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] LOW_BYTE_MASK = 16'h00FF;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACK,
		ST_WAIT
	} crd_state_t;

	// Bus request as it arrives on the receivers.
	typedef struct packed {
		logic [17:0] addr;
		logic [1:0] mode;
		logic msyn;
	} crd_req_t;

	// Decoded cycle: four selects and the gating signals.
	typedef struct packed {
		logic match;
		logic [3:0] sel;
		logic gate_in;
		logic gate_out_low;
		logic gate_out_high;
	} crd_dec_t;

endpackage

// *** core/crd_encoder.sv ***
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Column compressor
// ****************************************************************
module crd_encoder (
	input wire logic [11:0] column,
	output logic [7:0] code
);

	// Zones 12, 11, 0, 9 and 8 land on bits 7 to 3; zones 1 to 7 OR their octal numbers together.
	always_comb begin
		code[7:3] = {column[11:9], column[0], column[1]};
		code[2:0] = 3'h0;
		for (int z = 1; z <= 7; z++) begin
			if (column[9 - z]) begin
				code[2:0] = code[2:0] | z[2:0];
			end
		end
	end

endmodule // crd_encoder

`default_nettype wire

// *** tb/crd_host.sv ***
`timescale 1ns/10ps
`default_nettype none

// Bus master model; it holds the cycle until the answer, then releases.
module crd_host (
	input wire logic clk,
	input wire logic bus_ssyn,
	output logic [17:0] bus_addr,
	output logic [1:0] bus_mode,
	output logic bus_msyn,
	output logic [15:0] bus_data_in
);
	initial begin
		bus_addr = 18'h00000;
		bus_mode = 2'h0;
		bus_msyn = 1'b0;
		bus_data_in = 16'h0000;
	end

	// Lines are held steady until the acknowledge falls again.
	task automatic cycle(input logic [17:0] a, input logic [1:0] m, input logic [15:0] d, input int hold,
		output logic ack);
		int n;
		ack = 1'b0;
		@(negedge clk);
		bus_addr = a;
		bus_mode = m;
		bus_data_in = d;
		bus_msyn = 1'b1;
		for (n = 0; n < 12 && !ack; n++) begin
			@(posedge clk);
			ack = (bus_ssyn === 1'b1);
		end
		repeat (hold) @(posedge clk);
		@(negedge clk);
		bus_msyn = 1'b0;
		for (n = 0; n < 12 && bus_ssyn === 1'b1; n++) @(posedge clk);
		// Stay low until the strobe filter has seen the drop, or a stale strobe would take the next address.
		repeat (5) @(posedge clk);
		// Released lines show the inverse so stale values cannot pass.
		@(negedge clk);
		bus_addr = ~a;
		bus_mode = ~m;
		bus_data_in = ~d;
	endtask
endmodule // crd_host

`default_nettype wire

// *** tb/crd_slave_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module crd_slave_tb;
	logic clk = 1'b0, nrst = 1'b0, inh_n = 1'b1, ack, ssyn_q = 1'b0, msyn, oe, ssyn, cstb;
	logic [17:0] addr;
	logic [1:0] mode;
	logic [9:0] strap = crd_pkg::STRAP_DEFAULT;
	logic [11:0] col = 12'h000;
	logic [15:0] din, rstat = 16'h0000, dout, csc, stat_q = 16'h0000;
	logic [31:0] rng = 32'h0000000C;
	logic [16:0] exp_q[$];
	int n_fail = 0, total_checks = 0, n_wr = 0, n_stb = 0;

	always #50 clk = ~clk;

	crd_host i_host (.clk(clk), .bus_ssyn(ssyn), .bus_addr(addr), .bus_mode(mode), .bus_msyn(msyn),
		.bus_data_in(din));
	crd_slave i_dut (.clk(clk), .nrst(nrst), .bus_addr(addr), .bus_mode(mode), .bus_msyn(msyn),
		.acknowledge_inhibit_n(inh_n), .address_strap(strap), .bus_data_in(din), .column_image_buffer(col),
		.reader_status(rstat), .bus_data_out(dout), .bus_data_oe(oe), .bus_ssyn(ssyn),
		.card_status_control(csc), .command_strobe(cstb));

	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// Zones one to seven fold into an octal code by inclusive OR.
	function automatic logic [7:0] enc(input logic [11:0] c);
		logic [2:0] o;
		o = 3'h0;
		for (int k = 1; k <= 7; k++) if (c[9-k]) o |= 3'(k);
		return {c[11], c[10], c[9], c[0], c[1], o};
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One bus cycle; the expected answer is queued before the cycle starts.
	task automatic op(input logic [17:0] a, input logic [1:0] m, input logic hit);
		logic [15:0] e;
		logic [15:0] d;
		d = 16'(rnd());
		col = 12'(rnd());
		rstat = 16'(rnd());
		case (a[2:1])
			2'h0: e = stat_q | (rstat & ~crd_pkg::STATUS_WR_MASK);
			2'h1: e = {4'h0, col};
			2'h2: e = {8'h00, enc(col)};
			default: e = 16'h0000;
		endcase
		if (hit) exp_q.push_back({~m[1], e});
		i_host.cycle(a, m, d, int'(rnd() & 3), ack);
		chk("ack", {15'h0, hit}, {15'h0, ack});
		if (hit && m[1] && !a[0] && a[2:1] == 2'h0) begin
			stat_q = d & crd_pkg::STATUS_WR_MASK;
			n_wr++;
		end
		chk("status", stat_q, csc);
	endtask

	// Each rising acknowledge takes the oldest note off the queue.
	always @(posedge clk) begin
		ssyn_q <= ssyn;
		if (cstb) n_stb++;
		if (ssyn && !ssyn_q) begin
			if (exp_q.size() == 0) begin
				chk("note", 16'h0001, 16'h0000);
			end else begin
				chk("oe", {15'h0, exp_q[0][16]}, {15'h0, oe});
				if (exp_q[0][16]) chk("data", exp_q[0][15:0], dout);
				void'(exp_q.pop_front());
			end
		end
	end

	initial begin
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		for (int i = 0; i < 32; i++) op(crd_pkg::BLOCK_BASE | 18'(i[2:0]), i[4:3], 1'b1);
		$display("test decode done");
		for (int j = 3; j < 18; j++) op(crd_pkg::BLOCK_BASE ^ (18'h1 << j), 2'(rnd()), 1'b0);
		$display("test refuse done");
		for (int s = 0; s < 6; s++) begin
			strap = 10'(rnd());
			op({5'h1F, ~strap, 3'(rnd() & 6)}, 2'(rnd()), 1'b1);
		end
		$display("test strap done");
		inh_n = 1'b0;
		op(crd_pkg::BLOCK_BASE, crd_pkg::MODE_DATI, 1'b0);
		inh_n = 1'b1;
		chk("strobes", 16'(n_wr), 16'(n_stb));
		chk("notes left", 16'h0000, 16'(exp_q.size()));
		$display("test inhibit done");
		close_out();
	end

	initial begin
		#1000000;
		n_fail++;
		close_out();
	end
endmodule // crd_slave_tb

`default_nettype wire
